// ==== core/spm_pkg.sv ====
// constants and types for the serial port pin multiplexer
package spm_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CFG = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CLOCK_CONTROL_REG = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_SERIAL_IF_MODE_REG = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_SERIAL_IF_MASK_REG = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_PACFG = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_EVT = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_STAT = 8'h18;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_EXT_CLK1 = 2;
  localparam int CFG_TXD_OD = 3;
  localparam int CFG_CD_MANUAL = 4;
  localparam int CFG_CTS_MANUAL = 5;
  localparam int CFG_CTS_ABORT = 6;
  localparam int CFG_CD_SYNC = 7;
  localparam int CFG_EXT_CLK2 = 8;
  localparam int CFG_SECOND_SERIAL_CONTROLLER_MUX = 9;
  localparam int CFG_THIRD_SERIAL_CONTROLLER_MUX = 10;
  localparam int CK_BAUD_OUT_ONE_DIS = 11;
  localparam int CK_RX_CLOCK_ONE_DIS = 12;
  localparam int CK_TX_CLOCK_ONE_DIS = 13;
  localparam int SIM_CH1_LSB = 0;
  localparam int SIM_SDC_LSB = 6;
  localparam int MSK_S1_B1 = 0;
  localparam int MSK_S1_B2 = 1;
  localparam int MSK_S2_B1 = 2;
  localparam int MSK_S2_B2 = 3;
  localparam int PA_DED_LSB = 0;
  localparam int PA_DIR_LSB = 8;
  localparam int PA_DAT_LSB = 16;
  localparam int EVT_CD = 0;
  localparam int EVT_CTS = 1;
  localparam int STAT_PA_LSB = 8;

  // ----------------------------------------
  // reset values and timing
  // ----------------------------------------
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] CLOCK_CONTROL_REG_RST = 32'h0000_0000;
  localparam logic [31:0] SERIAL_IF_MODE_REG_RST = 32'h0000_0000;
  localparam logic [31:0] SERIAL_IF_MASK_REG_RST = 32'h0000_0000;
  localparam logic [31:0] PACFG_RST = 32'h0000_0000;
  localparam logic [1:0] HOLD_EDGES = 2'h2;
  localparam int SYNC_W = 13;

  typedef enum logic [1:0] {MODE_NMSI, MODE_IDL, MODE_GCI, MODE_PCM} spm_mode_e;

endpackage

// ==== core/spm_sync_if.sv ====
// carrier between the pin synchroniser and the multiplexer core
`timescale 1ns/1ns
interface spm_sync_if #(parameter int W = 13);
  logic [W-1:0] raw;
  logic [W-1:0] q;
  modport src (output raw, input q);
  modport dst (input raw, output q);
endinterface

// ==== core/spm_sync.sv ====
// two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
module spm_sync #(
  parameter int W = 13
) (
  input wire logic hclk,
  input wire logic hresetn,
  spm_sync_if.dst sif
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } spm_sync_s;

  spm_sync_s r;
  spm_sync_s next_r;

  always_comb
  begin
    next_r = r;
    next_r.s1 = sif.raw;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      r <= '0;
    else
      r <= next_r;
  end

  assign sif.q = r.s2;

endmodule

// ==== core/spm_top.sv ====
// serial port pin multiplexer with ahb-lite register slave
// --------------------------------------------------------
// --------------------------------------------------------
//
// Chosen here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ns
module spm_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [2:0] brg_clk,
  input wire logic [2:0] scc_txd,
  input wire logic [2:0] scc_tx_req,
  input wire logic l1_req,
  input wire logic b1_win,
  input wire logic b2_win,
  input wire logic layer1_rx_data,
  input wire logic rx_clock_one_i,
  input wire logic tx_clock_one_i,
  input wire logic carrier_detect_one,
  input wire logic clear_to_send_one,
  input wire logic [7:0] port_a_i,
  output logic layer1_tx_data,
  output logic layer1_tx_data_oe_n,
  output logic rx_clock_one_o,
  output logic rx_clock_one_oe_n,
  output logic tx_clock_one_o,
  output logic tx_clock_one_oe_n,
  output logic request_to_send_one,
  output logic baud_out_one,
  output logic baud_out_three,
  output logic tx_clock_three_o,
  output logic tx_clock_three_oe_n,
  output logic [7:0] port_a_o,
  output logic [7:0] port_a_oe_n,
  output logic [2:0] scc_rxd,
  output logic [2:0] scc_rx_en,
  output logic first_serial_controller_tx_abort,
  output logic cd_ext_int,
  output logic cts_ext_int,
  output logic ext_sync
);
  import spm_pkg::*;

  typedef struct packed {
    logic ap_wr;
    logic [ADDR_W-1:0] ap_addr;
    logic [31:0] hrdata;
    logic hready;
    logic [31:0] cfg;
    logic [31:0] clock_control_reg;
    logic [31:0] serial_if_mode_reg;
    logic [31:0] serial_if_mask_reg;
    logic [31:0] pacfg;
    logic [1:0] evt;
    logic cd_ref;
    logic cts_ref;
    logic [1:0] cd_cnt;
    logic [1:0] cts_cnt;
    logic rclk_prev;
    logic tclk_prev;
    logic txd_o;
    logic txd_oe_n;
    logic rclk_o;
    logic rclk_oe_n;
    logic tclk_o;
    logic tclk_oe_n;
    logic rts_o;
    logic baud1;
    logic baud3;
    logic tclk3_o;
    logic tclk3_oe_n;
    logic [7:0] pa_o;
    logic [7:0] pa_oe_n;
    logic [2:0] rxd;
    logic [2:0] rx_en;
    logic abort;
    logic cd_int;
    logic cts_int;
    logic sync_o;
  } spm_top_s;

  spm_top_s r;
  spm_top_s next_r;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  spm_sync_if #(.W(SYNC_W)) sif ();
  assign sif.raw = {port_a_i, clear_to_send_one, carrier_detect_one,
                    tx_clock_one_i, rx_clock_one_i, layer1_rx_data};

  spm_sync #(.W(SYNC_W)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .sif(sif)
  );

  logic rxd_s, rclk_s, tclk_s, cd_s, cts_s;
  logic [7:0] pa_s;
  assign {pa_s, cts_s, cd_s, tclk_s, rclk_s, rxd_s} = sif.q;

  // ----------------------------------------
  // derived control
  // ----------------------------------------
  spm_mode_e mode;
  logic nmsi, ext1, ext2, second_serial_controller_mux, third_serial_controller_mux;
  logic [1:0] pcm_code;
  logic [1:0] pcm_scc;
  logic [2:0] pcm_hot;
  logic rx_edge, tx_edge, cd_hit, cts_hit;
  logic data_strobe_one, data_strobe_two, data_strobe_two_nmsi;
  logic [7:0] ded_o, ded_oe_n;
  logic [31:0] rd_val;

  always_comb
  begin
    mode = spm_mode_e'(r.cfg[CFG_MODE_LSB +: 2]);
    nmsi = (mode == MODE_NMSI);
    ext1 = r.cfg[CFG_EXT_CLK1];
    ext2 = r.cfg[CFG_EXT_CLK2];
    second_serial_controller_mux = r.cfg[CFG_SECOND_SERIAL_CONTROLLER_MUX];
    third_serial_controller_mux = r.cfg[CFG_THIRD_SERIAL_CONTROLLER_MUX];
    pcm_code = {cd_s, tclk_s};
    pcm_scc = 2'({r.serial_if_mode_reg[SIM_CH1_LSB +: 6], 2'h3} >> (3'h2 * pcm_code));
    pcm_hot = '0;
    if (mode == MODE_PCM && pcm_code != 2'h0 && pcm_scc != 2'h3)
      pcm_hot[pcm_scc] = 1'b1;
    rx_edge = (ext1 ? rclk_s : brg_clk[0]) & ~r.rclk_prev;
    tx_edge = (ext1 ? tclk_s : brg_clk[0]) & ~r.tclk_prev;
    cd_hit = nmsi && cd_s != r.cd_ref && rx_edge && r.cd_cnt == HOLD_EDGES - 2'h1;
    cts_hit = nmsi && cts_s != r.cts_ref && tx_edge
              && r.cts_cnt == HOLD_EDGES - 2'h1;
    data_strobe_one = (b1_win & r.serial_if_mask_reg[MSK_S1_B1]) | (b2_win & r.serial_if_mask_reg[MSK_S1_B2]);
    data_strobe_two = (b1_win & r.serial_if_mask_reg[MSK_S2_B1]) | (b2_win & r.serial_if_mask_reg[MSK_S2_B2]);
    data_strobe_two_nmsi = r.serial_if_mode_reg[SIM_SDC_LSB +: 2] != 2'h0;
    // dedicated second-port functions, as the first port in nonmux mode
    ded_o = '0;
    ded_oe_n = '1;
    ded_o[1] = scc_txd[1];
    ded_oe_n[1] = 1'b0;
    ded_o[2] = brg_clk[1];
    ded_oe_n[2] = ext2;
    ded_o[3] = brg_clk[1];
    ded_oe_n[3] = ext2 & ~second_serial_controller_mux;
    ded_o[5] = ~scc_tx_req[1];
    ded_oe_n[5] = 1'b0;
    ded_oe_n[7] = 1'b0;
    if (mode == MODE_IDL || mode == MODE_GCI)
      ded_o[7] = data_strobe_two;
    else if (data_strobe_two_nmsi)
      ded_o[7] = data_strobe_two;
    else
      ded_o[7] = ~brg_clk[1];
    rd_val = '0;
    case (haddr[ADDR_W-1:0])
      OFF_CFG: rd_val = r.cfg;
      OFF_CLOCK_CONTROL_REG: rd_val = r.clock_control_reg;
      OFF_SERIAL_IF_MODE_REG: rd_val = r.serial_if_mode_reg;
      OFF_SERIAL_IF_MASK_REG: rd_val = r.serial_if_mask_reg;
      OFF_PACFG: rd_val = r.pacfg;
      OFF_EVT: rd_val = {30'h0, r.evt};
      OFF_STAT: rd_val = {16'h0, pa_s, 6'h0, cts_s, cd_s};
      default: rd_val = '0;
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    next_r = r;
    next_r.hready = 1'b1;
    next_r.ap_wr = hsel & htrans[1] & hready & hwrite;
    next_r.ap_addr = haddr[ADDR_W-1:0];
    if (hsel & htrans[1] & hready & ~hwrite)
      next_r.hrdata = rd_val;
    if (r.ap_wr)
    begin
      case (r.ap_addr)
        OFF_CFG: next_r.cfg = hwdata;
        OFF_CLOCK_CONTROL_REG: next_r.clock_control_reg = hwdata;
        OFF_SERIAL_IF_MODE_REG: next_r.serial_if_mode_reg = hwdata;
        OFF_SERIAL_IF_MASK_REG: next_r.serial_if_mask_reg = hwdata;
        OFF_PACFG: next_r.pacfg = hwdata;
        OFF_EVT: next_r.evt = r.evt & ~hwdata[1:0];
        default: next_r.evt = next_r.evt;
      endcase
    end
    // modem change filters
    next_r.rclk_prev = ext1 ? rclk_s : brg_clk[0];
    next_r.tclk_prev = ext1 ? tclk_s : brg_clk[0];
    if (cd_s == r.cd_ref)
      next_r.cd_cnt = 2'h0;
    else if (cd_hit)
    begin
      next_r.cd_cnt = 2'h0;
      next_r.cd_ref = cd_s;
    end
    else if (rx_edge)
      next_r.cd_cnt = r.cd_cnt + 2'h1;
    if (cts_s == r.cts_ref)
      next_r.cts_cnt = 2'h0;
    else if (cts_hit)
    begin
      next_r.cts_cnt = 2'h0;
      next_r.cts_ref = cts_s;
    end
    else if (tx_edge)
      next_r.cts_cnt = r.cts_cnt + 2'h1;
    if (cd_hit)
      next_r.evt[EVT_CD] = 1'b1;
    if (cts_hit)
      next_r.evt[EVT_CTS] = 1'b1;
    next_r.abort = cts_hit & ~r.cfg[CFG_CTS_MANUAL] & r.cfg[CFG_CTS_ABORT];
    next_r.cd_int = cd_hit & r.cfg[CFG_CD_MANUAL];
    next_r.cts_int = cts_hit & r.cfg[CFG_CTS_MANUAL];
    next_r.sync_o = nmsi & r.cfg[CFG_CD_SYNC] & ~cd_s;
    // first-port pins
    next_r.rclk_o = brg_clk[0];
    next_r.rclk_oe_n = ~nmsi | ext1 | r.clock_control_reg[CK_RX_CLOCK_ONE_DIS];
    next_r.baud1 = r.clock_control_reg[CK_BAUD_OUT_ONE_DIS] ? 1'b1 : ~brg_clk[0];
    next_r.txd_o = scc_txd[0];
    next_r.txd_oe_n = 1'b0;
    next_r.tclk_o = brg_clk[0];
    next_r.tclk_oe_n = 1'b1;
    next_r.rts_o = ~scc_tx_req[0];
    next_r.rxd = {rxd_s, rxd_s, rxd_s};
    next_r.rx_en = 3'h0;
    case (mode)
      MODE_NMSI:
      begin
        next_r.tclk_oe_n = ext1 | r.clock_control_reg[CK_TX_CLOCK_ONE_DIS];
        if (r.cfg[CFG_TXD_OD])
        begin
          next_r.txd_o = 1'b0;
          next_r.txd_oe_n = scc_txd[0];
        end
        next_r.rx_en = 3'h1;
      end
      MODE_IDL:
      begin
        next_r.tclk_o = data_strobe_one;
        next_r.tclk_oe_n = 1'b0;
        next_r.rts_o = l1_req;
        next_r.rx_en = 3'h1;
      end
      MODE_GCI:
      begin
        next_r.tclk_o = data_strobe_one;
        next_r.tclk_oe_n = 1'b0;
        next_r.rts_o = rclk_s;
        next_r.txd_o = 1'b0;
        next_r.txd_oe_n = scc_txd[0];
        next_r.rx_en = 3'h1;
      end
      MODE_PCM:
      begin
        next_r.txd_o = scc_txd[pcm_scc == 2'h3 ? 2'h0 : pcm_scc];
        next_r.txd_oe_n = (pcm_hot == 3'h0);
        next_r.rx_en = pcm_hot;
      end
      default: next_r.rx_en = 3'h0;
    endcase
    // third controller baud routing
    next_r.baud3 = third_serial_controller_mux ? 1'b1 : ~brg_clk[2];
    next_r.tclk3_o = brg_clk[2];
    next_r.tclk3_oe_n = ~third_serial_controller_mux;
  end

  // ----------------------------------------
  // second-port pin selection
  // ----------------------------------------
  logic [7:0] next_pa_o, next_pa_oe_n;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_pa
      always_comb
      begin
        if (r.pacfg[PA_DED_LSB + gi])
        begin
          next_pa_o[gi] = ded_o[gi];
          next_pa_oe_n[gi] = ded_oe_n[gi];
        end
        else
        begin
          next_pa_o[gi] = r.pacfg[PA_DAT_LSB + gi];
          next_pa_oe_n[gi] = ~r.pacfg[PA_DIR_LSB + gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      r <= '0;
      r.hready <= 1'b1;
      r.cfg <= CFG_RST;
      r.clock_control_reg <= CLOCK_CONTROL_REG_RST;
      r.serial_if_mode_reg <= SERIAL_IF_MODE_REG_RST;
      r.serial_if_mask_reg <= SERIAL_IF_MASK_REG_RST;
      r.pacfg <= PACFG_RST;
      r.cd_ref <= 1'b1;
      r.cts_ref <= 1'b1;
      r.txd_oe_n <= 1'b1;
      r.rclk_oe_n <= 1'b1;
      r.tclk_oe_n <= 1'b1;
      r.tclk3_oe_n <= 1'b1;
      r.rts_o <= 1'b1;
      r.baud1 <= 1'b1;
      r.baud3 <= 1'b1;
      r.pa_oe_n <= '1;
    end
    else
    begin
      r <= next_r;
      r.pa_o <= next_pa_o;
      r.pa_oe_n <= next_pa_oe_n;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign hrdata = r.hrdata;
  assign hreadyout = r.hready;
  assign hresp = 1'b0;
  assign layer1_tx_data = r.txd_o;
  assign layer1_tx_data_oe_n = r.txd_oe_n;
  assign rx_clock_one_o = r.rclk_o;
  assign rx_clock_one_oe_n = r.rclk_oe_n;
  assign tx_clock_one_o = r.tclk_o;
  assign tx_clock_one_oe_n = r.tclk_oe_n;
  assign request_to_send_one = r.rts_o;
  assign baud_out_one = r.baud1;
  assign baud_out_three = r.baud3;
  assign tx_clock_three_o = r.tclk3_o;
  assign tx_clock_three_oe_n = r.tclk3_oe_n;
  assign port_a_o = r.pa_o;
  assign port_a_oe_n = r.pa_oe_n;
  assign scc_rxd = r.rxd;
  assign scc_rx_en = r.rx_en;
  assign first_serial_controller_tx_abort = r.abort;
  assign cd_ext_int = r.cd_int;
  assign cts_ext_int = r.cts_int;
  assign ext_sync = r.sync_o;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_baud_out_one_held_high: assert property (r.clock_control_reg[CK_BAUD_OUT_ONE_DIS] |=> baud_out_one)
    else $error("baud out one not high while disabled");
  a_baud_out_one_inverse: assert property (!r.clock_control_reg[CK_BAUD_OUT_ONE_DIS] |=> baud_out_one == !$past(brg_clk[0]))
    else $error("baud out one not inverted baud clock");
  a_rclk_tristate: assert property (r.clock_control_reg[CK_RX_CLOCK_ONE_DIS] |=> rx_clock_one_oe_n)
    else $error("rx clock driven while disabled");
  a_tclk_nmsi_dir: assert property (nmsi && !ext1 && !r.clock_control_reg[CK_TX_CLOCK_ONE_DIS]
    |=> !tx_clock_one_oe_n && tx_clock_one_o == $past(brg_clk[0]))
    else $error("tx clock not driving baud clock");
  a_pcm_idle_code: assert property (mode == MODE_PCM && pcm_code == 2'h0
    |=> layer1_tx_data_oe_n && scc_rx_en == 3'h0)
    else $error("pcm idle code not three-stated");
  a_pcm_channel_route: assert property (mode == MODE_PCM && pcm_code == 2'h1
    && r.serial_if_mode_reg[SIM_CH1_LSB +: 2] == 2'h0 |=> scc_rx_en == 3'h1)
    else $error("pcm channel misrouted");
  a_gci_open_drain: assert property (mode == MODE_GCI |=> layer1_tx_data_oe_n || !layer1_tx_data)
    else $error("gci tx data driven high");
  a_rts_request: assert property (nmsi && scc_tx_req[0] |=> !request_to_send_one)
    else $error("rts not asserted with data pending");
  a_cd_event_set: assert property (cd_hit |=> r.evt[EVT_CD] ##1 (r.evt[EVT_CD] || $past(r.ap_wr)))
    else $error("carrier event bit not set");
  a_cts_abort_pulse: assert property (cts_hit && r.cfg[CFG_CTS_ABORT]
    && !r.cfg[CFG_CTS_MANUAL] |=> first_serial_controller_tx_abort ##1 !first_serial_controller_tx_abort || $past(cts_hit))
    else $error("cts abort pulse missing");
  a_pa7_gpio_stop: assert property (!r.pacfg[PA_DED_LSB + 7]
    |=> port_a_o[7] == $past(r.pacfg[PA_DAT_LSB + 7]))
    else $error("port bit 7 not gpio");

  c_cd_event: cover property (cd_hit);
  c_cts_abort: cover property (first_serial_controller_tx_abort);
  c_pcm_ch3: cover property (mode == MODE_PCM && pcm_code == 2'h3);
  c_gci_strobe: cover property (mode == MODE_GCI && data_strobe_one);

endmodule

// ==== testbench/spm_l1_model.sv ====
// layer-1 transceiver model facing the multiplexed serial pins
`timescale 1ns/1ns
module spm_l1_model (
  input wire logic run,
  input wire logic [1:0] code,
  output logic l1_clk,
  output logic sync_low,
  output logic sync_high,
  output logic rx_data
);
  // ----------------------------------------
  // link clock, stands still outside frames
  // ----------------------------------------
  initial
  begin
    l1_clk = 1'b0;
    rx_data = 1'b0;
  end
  always #160
  begin
    l1_clk <= run ? ~l1_clk : 1'b0;
    rx_data <= ~rx_data;
  end
  // ----------------------------------------
  // channel sync code on the two sync pins
  // ----------------------------------------
  assign sync_low = code[0];
  assign sync_high = code[1];
endmodule

// ==== testbench/spm_top_test.sv ====
// self-checking bench for the serial port pin multiplexer
`timescale 1ns/1ns
module spm_top_test;
  import spm_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0, code = 2'h0;
  logic [2:0] hsize = 3'h2, scc_tx_req = 3'h0, brg_clk, scc_rxd, scc_rx_en;
  logic [3:0] brg_div = 4'h0;
  logic l1_req = 1'b0, cd_n = 1'b1, cts_n = 1'b1, run = 1'b0, pcm = 1'b0;
  logic b1 = 1'b0, b2 = 1'b0, cd_int, cts_int, esync, b3, t3_o, t3_oe_n;
  logic [2:0] saw;
  logic hreadyout, hresp, txd, txd_oe_n, rx_o, rx_oe_n, tx_o, tx_oe_n, rts, baud1, abort;
  logic m_clk, m_sy0, m_sy1, m_rxd, rx_pin, tx_pin, cd_pin;
  logic [7:0] pa_o, pa_oe_n, pa_pin;
  int n_errors = 0, cmp_count = 0;
  always #20 hclk = ~hclk;
  always @(posedge hclk) brg_div <= brg_div + 4'h1;
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
      saw <= 3'h0;
    else
      saw <= saw | {abort, cd_int, cts_int};
  assign brg_clk = {1'b1, 1'b0, brg_div[1]};
  // ----------------------------------------
  // wire levels from all drivers
  // ----------------------------------------
  assign rx_pin = rx_oe_n ? m_clk : rx_o;
  assign tx_pin = tx_oe_n ? (pcm ? m_sy0 : m_clk) : tx_o;
  assign cd_pin = pcm ? m_sy1 : cd_n;
  assign pa_pin = (pa_o & ~pa_oe_n) | (8'h5a & pa_oe_n);
  spm_l1_model far (.run(run), .code(code), .l1_clk(m_clk), .sync_low(m_sy0),
    .sync_high(m_sy1), .rx_data(m_rxd));
  spm_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .brg_clk(brg_clk), .scc_txd({3{brg_div[2]}}),
    .scc_tx_req(scc_tx_req), .l1_req(l1_req), .b1_win(b1), .b2_win(b2),
    .layer1_rx_data(m_rxd), .rx_clock_one_i(rx_pin), .tx_clock_one_i(tx_pin),
    .carrier_detect_one(cd_pin), .clear_to_send_one(cts_n), .port_a_i(pa_pin),
    .layer1_tx_data(txd), .layer1_tx_data_oe_n(txd_oe_n), .rx_clock_one_o(rx_o),
    .rx_clock_one_oe_n(rx_oe_n), .tx_clock_one_o(tx_o), .tx_clock_one_oe_n(tx_oe_n),
    .request_to_send_one(rts), .baud_out_one(baud1), .baud_out_three(b3),
    .tx_clock_three_o(t3_o), .tx_clock_three_oe_n(t3_oe_n),
    .port_a_o(pa_o), .port_a_oe_n(pa_oe_n),
    .scc_rxd(scc_rxd), .scc_rx_en(scc_rx_en), .first_serial_controller_tx_abort(abort), .cd_ext_int(cd_int),
    .cts_ext_int(cts_int), .ext_sync(esync));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1)
    begin
      n_errors++;
      give_verdict();
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] t;
    ahb(1'b1, a, d, t);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] t);
    ahb(1'b0, a, 32'h0, t);
  endtask
  task automatic settle;
    repeat (6) @(posedge hclk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    logic [31:0] t;
    for (int a = 0; a <= 5; a++)
    begin
      rd(8'(a * 4), t);
      check(t, 32'h0);
    end
    check({hresp, hreadyout}, 2'b01);
    wr(OFF_CLOCK_CONTROL_REG, 32'h0000_3800);
    rd(OFF_CLOCK_CONTROL_REG, t);
    check(t & 32'h0000_3800, 32'h0000_3800);
    wr(8'h1c, 32'hffff_ffff);
    rd(8'h1c, t);
    check(t, 32'h0);
    wr(OFF_CLOCK_CONTROL_REG, 32'h0);
    $display("test registers done");
  endtask
  task automatic t_baud;
    logic prev;
    @(posedge hclk);
    prev = brg_clk[0];
    repeat (12)
    begin
      @(posedge hclk);
      check(baud1, {~prev});
      prev = brg_clk[0];
    end
    wr(OFF_CLOCK_CONTROL_REG, 32'h0000_0800);
    settle();
    repeat (6)
    begin
      @(posedge hclk);
      check(baud1, 1'b1);
    end
    wr(OFF_CLOCK_CONTROL_REG, 32'h0);
    $display("test baud one done");
  endtask
  task automatic t_clocks;
    settle();
    check({rx_oe_n, tx_oe_n}, 2'b00);
    wr(OFF_CLOCK_CONTROL_REG, 32'h0000_1000);
    settle();
    check({rx_oe_n, tx_oe_n}, 2'b10);
    wr(OFF_CLOCK_CONTROL_REG, 32'h0000_2000);
    settle();
    check({rx_oe_n, tx_oe_n}, 2'b01);
    wr(OFF_CLOCK_CONTROL_REG, 32'h0000_3000);
    wr(OFF_CFG, 32'h0000_0004);
    wr(OFF_CLOCK_CONTROL_REG, 32'h0);
    settle();
    check({rx_oe_n, tx_oe_n}, 2'b11);
    wr(OFF_CLOCK_CONTROL_REG, 32'h0000_3000);
    wr(OFF_CFG, 32'h0);
    wr(OFF_CLOCK_CONTROL_REG, 32'h0);
    $display("test clock pins done");
  endtask
  task automatic t_rts;
    logic [2:0] hc, hd;
    scc_tx_req <= 3'h1;
    settle();
    check(rts, 1'b0);
    scc_tx_req <= 3'h0;
    settle();
    check(rts, 1'b1);
    wr(OFF_CFG, 32'h0000_0001);
    l1_req <= 1'b1;
    settle();
    check({rts, tx_oe_n}, 2'b10);
    l1_req <= 1'b0;
    settle();
    check(rts, 1'b0);
    wr(OFF_SERIAL_IF_MASK_REG, 32'h0000_0009);
    wr(OFF_PACFG, 32'h0000_0080);
    b1 <= 1'b1;
    settle();
    check({tx_o, pa_o[7]}, 2'b10);
    b1 <= 1'b0;
    b2 <= 1'b1;
    settle();
    check({tx_o, pa_o[7]}, 2'b01);
    b2 <= 1'b0;
    wr(OFF_SERIAL_IF_MASK_REG, 32'h0);
    wr(OFF_PACFG, 32'h0);
    wr(OFF_CFG, 32'h0000_0002);
    run <= 1'b1;
    repeat (3)
    begin
      @(posedge hclk);
      hc = {hc[1:0], m_clk};
      hd = {hd[1:0], m_rxd};
    end
    repeat (12)
    begin
      @(posedge hclk);
      check({rts, txd, scc_rxd}, {hc[2], 1'b0, {3{hd[2]}}});
      hc = {hc[1:0], m_clk};
      hd = {hd[1:0], m_rxd};
    end
    run <= 1'b0;
    wr(OFF_CFG, 32'h0);
    $display("test request pin done");
  endtask
  task automatic t_events;
    logic [31:0] t;
    wr(OFF_CFG, 32'h0000_0040);
    wr(OFF_EVT, 32'h3);
    cd_n <= 1'b0;
    cts_n <= 1'b0;
    repeat (40) @(posedge hclk);
    rd(OFF_EVT, t);
    check(t & 32'h3, 32'h3);
    check(saw, 3'b100);
    rd(OFF_STAT, t);
    check(t & 32'h3, 32'h0);
    wr(OFF_EVT, 32'h3);
    rd(OFF_EVT, t);
    check(t & 32'h3, 32'h0);
    cd_n <= 1'b1;
    cts_n <= 1'b1;
    repeat (40) @(posedge hclk);
    rd(OFF_STAT, t);
    check(t & 32'h3, 32'h3);
    wr(OFF_EVT, 32'h3);
    wr(OFF_CFG, 32'h0000_00b0);
    cd_n <= 1'b0;
    cts_n <= 1'b0;
    repeat (40) @(posedge hclk);
    check({saw, esync}, 4'hf);
    cd_n <= 1'b1;
    cts_n <= 1'b1;
    repeat (40) @(posedge hclk);
    check(esync, 1'b0);
    wr(OFF_EVT, 32'h3);
    wr(OFF_CFG, 32'h0);
    $display("test modem events done");
  endtask
  task automatic t_pcm;
    run <= 1'b1;
    pcm <= 1'b1;
    wr(OFF_SERIAL_IF_MODE_REG, 32'h0000_0024);
    wr(OFF_CFG, 32'h0000_0003);
    for (int c = 0; c < 4; c++)
    begin
      code <= 2'(c);
      settle();
      check(scc_rx_en, (c == 0) ? 3'h0 : 3'(1 << (c - 1)));
      check({txd_oe_n, tx_oe_n}, {c == 0, 1'b1});
    end
    wr(OFF_CFG, 32'h0);
    run <= 1'b0;
    pcm <= 1'b0;
    code <= 2'h0;
    $display("test pcm channels done");
  endtask
  task automatic t_port;
    wr(OFF_PACFG, 32'h0080_8000);
    settle();
    check({pa_oe_n[7], pa_o[7]}, 2'b01);
    wr(OFF_PACFG, 32'h0000_8000);
    settle();
    check({pa_oe_n[7], pa_o[7]}, 2'b00);
    wr(OFF_PACFG, 32'h0000_0080);
    settle();
    check({pa_oe_n[7], pa_o[7]}, {1'b0, ~brg_clk[1]});
    wr(OFF_PACFG, 32'h0);
    check({b3, t3_oe_n}, 2'b01);
    wr(OFF_CFG, 32'h0000_0400);
    settle();
    check({b3, t3_oe_n, t3_o}, 3'b101);
    wr(OFF_CFG, 32'h0);
    $display("test port bit seven done");
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_baud();
    t_clocks();
    t_rts();
    t_events();
    t_pcm();
    t_port();
    give_verdict();
  end
  initial
  begin
    #2000000;
    n_errors++;
    give_verdict();
  end
endmodule
